// ===== rtl/citim_pkg.sv
package citim_pkg;

  // instruction classes offered to the timing decoder
  typedef enum logic [3:0] {
    CITIM_CLS_NONE,
    CITIM_CLS_FMT1,
    CITIM_CLS_FMT2_ROT,
    CITIM_CLS_FMT2_PUSH,
    CITIM_CLS_FMT2_CALL,
    CITIM_CLS_JUMP,
    CITIM_CLS_INTERRUPT_EXIT,
    CITIM_CLS_SUBROUTINE_EXIT,
    CITIM_CLS_IRQ_SERVICE,
    CITIM_CLS_WATCHDOG_RESET,
    CITIM_CLS_PIN_RESET
  } citim_class_t;

  // addressing modes of one operand
  typedef enum logic [2:0] {
    CITIM_AM_REG,
    CITIM_AM_IND,
    CITIM_AM_AUTOINC,
    CITIM_AM_IMM,
    CITIM_AM_INDEXED,
    CITIM_AM_SYMBOLIC,
    CITIM_AM_ABSOLUTE,
    CITIM_AM_PC
  } citim_amode_t;

  typedef enum logic [1:0] {
    CITIM_EXT_NONE,
    CITIM_EXT_REGISTER,
    CITIM_EXT_NONREG
  } citim_ext_t;

  typedef struct packed {
    citim_class_t cls;
    citim_amode_t src_mode;
    citim_amode_t dst_mode;
    logic fast_op;
    logic ext_free;
    logic [15:0] ext_word;
  } citim_req_t;

  typedef struct packed {
    logic [2:0] cycles;
    // an extended three-word form reaches four words
    logic [2:0] words;
    citim_ext_t ext_kind;
    logic wide;
    logic ext_err;
  } citim_rsp_t;

  localparam logic [15:0] CITIM_EXT_LO = 16'h1800;
  localparam logic [15:0] CITIM_EXT_HI = 16'h1FFF;
  localparam logic [19:0] CITIM_WORD_BYTES = 20'h00002;
  localparam logic [19:0] CITIM_PC_RESET = 20'h00000;

  localparam logic [2:0] CITIM_CYC_INTERRUPT_EXIT = 3'h5;
  localparam logic [2:0] CITIM_CYC_SUBROUTINE_EXIT = 3'h4;
  localparam logic [2:0] CITIM_CYC_IRQ_SERVICE = 3'h6;
  localparam logic [2:0] CITIM_CYC_RESET = 3'h4;
  localparam logic [2:0] CITIM_CYC_JUMP = 3'h2;

  localparam logic [2:0] CITIM_CYC_ROT_REG = 3'h1;
  localparam logic [2:0] CITIM_CYC_ROT_IND = 3'h3;
  localparam logic [2:0] CITIM_CYC_ROT_MEM = 3'h4;
  localparam logic [2:0] CITIM_CYC_PUSH_SHORT = 3'h3;
  localparam logic [2:0] CITIM_CYC_PUSH_MEM = 3'h4;
  localparam logic [2:0] CITIM_CYC_CALL_SHORT = 3'h4;
  localparam logic [2:0] CITIM_CYC_CALL_IDX = 3'h5;
  localparam logic [2:0] CITIM_CYC_CALL_ABS = 3'h6;

endpackage

// ===== rtl/citim_decoder.sv
// Overview of operation
// - cycle count follows format and operand modes, counted in core clocks
// - interrupt_exit is one word and five cycles
// - subroutine_exit is one word and four cycles
// - interrupt service takes six cycles before first handler instruction
// - watchdog reset and pin reset each take four cycles
// - rotate, swap, extend: 1 register, 3 indirect, 4 indexed/absolute
// - push: 3 short modes, 4 indexed, symbolic or absolute
// - call: 4 short, 5 indexed or symbolic, 6 absolute
// - jumps are one word and two cycles, taken or not
// - register source: 1 to register, 3 to pc, 4 to memory
// - indirect source: 2 to register, 4 to pc, 5 to memory
// - immediate source: 2 to register, 3 to pc, 5 to memory
// - indexed source: 3 to register, 5 to pc, 6 to memory
// - copy, mask-test, compare to memory take one cycle less
// - extended forms add a leading word unless defined without one
// - after an extension word operands are 20-bit
// - extension kind: register form versus all other mode combinations
// - opcodes 1800h to 1FFFh are extension words
`timescale 1ns/10ps
`default_nettype none

module citim_decoder
  import citim_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire citim_pkg::citim_req_t i_req,
  output logic o_ready,
  output var citim_pkg::citim_rsp_t o_rsp,
  output logic o_rsp_valid,
  output logic [19:0] o_pc,
  output logic o_busy,
  output logic o_last_cycle
);
  import citim_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_mem(input citim_amode_t m);
    is_mem = (m == CITIM_AM_INDEXED) || (m == CITIM_AM_SYMBOLIC) ||
             (m == CITIM_AM_ABSOLUTE);
  endfunction

  function automatic logic is_short(input citim_amode_t m);
    is_short = (m == CITIM_AM_IND) || (m == CITIM_AM_AUTOINC);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // combinational timing decode

  logic [2:0] cyc_nxt;
  logic [1:0] words_nxt;
  logic is_ext;
  citim_ext_t kind_nxt;
  logic fmt1_dst_mem;

  // mode-based count; of the operation itself only fast_op counts, on memory destinations
  always_comb begin
    cyc_nxt = 3'h1;
    words_nxt = 2'h1;
    fmt1_dst_mem = is_mem(i_req.dst_mode);
    case (i_req.cls)
      CITIM_CLS_INTERRUPT_EXIT: begin
        cyc_nxt = CITIM_CYC_INTERRUPT_EXIT;
        words_nxt = 2'h1;
      end
      CITIM_CLS_SUBROUTINE_EXIT: begin
        cyc_nxt = CITIM_CYC_SUBROUTINE_EXIT;
        words_nxt = 2'h1;
      end
      CITIM_CLS_IRQ_SERVICE: begin
        cyc_nxt = CITIM_CYC_IRQ_SERVICE;
        words_nxt = 2'h0;
      end
      CITIM_CLS_WATCHDOG_RESET, CITIM_CLS_PIN_RESET: begin
        cyc_nxt = CITIM_CYC_RESET;
        words_nxt = 2'h0;
      end
      CITIM_CLS_JUMP: begin
        cyc_nxt = CITIM_CYC_JUMP;
        words_nxt = 2'h1;
      end
      CITIM_CLS_FMT2_ROT: begin
        // immediate is not a legal mode here; treated like register
        if (is_mem(i_req.dst_mode)) begin
          cyc_nxt = CITIM_CYC_ROT_MEM;
          words_nxt = 2'h2;
        end else if (is_short(i_req.dst_mode)) begin
          cyc_nxt = CITIM_CYC_ROT_IND;
          words_nxt = 2'h1;
        end else begin
          cyc_nxt = CITIM_CYC_ROT_REG;
          words_nxt = 2'h1;
        end
      end
      CITIM_CLS_FMT2_PUSH: begin
        if (is_mem(i_req.dst_mode)) begin
          cyc_nxt = CITIM_CYC_PUSH_MEM;
          words_nxt = 2'h2;
        end else begin
          cyc_nxt = CITIM_CYC_PUSH_SHORT;
          words_nxt = (i_req.dst_mode == CITIM_AM_IMM) ? 2'h2 : 2'h1;
        end
      end
      CITIM_CLS_FMT2_CALL: begin
        if (i_req.dst_mode == CITIM_AM_ABSOLUTE) begin
          cyc_nxt = CITIM_CYC_CALL_ABS;
          words_nxt = 2'h2;
        end else if (is_mem(i_req.dst_mode)) begin
          cyc_nxt = CITIM_CYC_CALL_IDX;
          words_nxt = 2'h2;
        end else begin
          cyc_nxt = CITIM_CYC_CALL_SHORT;
          words_nxt = (i_req.dst_mode == CITIM_AM_IMM) ? 2'h2 : 2'h1;
        end
      end
      CITIM_CLS_FMT1: begin
        if (is_mem(i_req.src_mode)) begin
          // indexed, symbolic, absolute source
          words_nxt = fmt1_dst_mem ? 2'h3 : 2'h2;
          if (fmt1_dst_mem) begin
            cyc_nxt = 3'h6;
          end else if (i_req.dst_mode == CITIM_AM_PC) begin
            cyc_nxt = 3'h5;
          end else begin
            cyc_nxt = 3'h3;
          end
        end else if (i_req.src_mode == CITIM_AM_IMM) begin
          words_nxt = fmt1_dst_mem ? 2'h3 : 2'h2;
          if (fmt1_dst_mem) begin
            cyc_nxt = 3'h5;
          end else if (i_req.dst_mode == CITIM_AM_PC) begin
            cyc_nxt = 3'h3;
          end else begin
            cyc_nxt = 3'h2;
          end
        end else if (is_short(i_req.src_mode)) begin
          words_nxt = fmt1_dst_mem ? 2'h2 : 2'h1;
          if (fmt1_dst_mem) begin
            cyc_nxt = 3'h5;
          end else if (i_req.dst_mode == CITIM_AM_PC) begin
            cyc_nxt = 3'h4;
          end else begin
            cyc_nxt = 3'h2;
          end
        end else begin
          words_nxt = fmt1_dst_mem ? 2'h2 : 2'h1;
          if (fmt1_dst_mem) begin
            cyc_nxt = 3'h4;
          end else if (i_req.dst_mode == CITIM_AM_PC) begin
            cyc_nxt = 3'h3;
          end else begin
            cyc_nxt = 3'h1;
          end
        end
        if (fmt1_dst_mem && i_req.fast_op) begin
          cyc_nxt = cyc_nxt - 3'h1;
        end
      end
      default: begin
        cyc_nxt = 3'h1;
        words_nxt = 2'h0;
      end
    endcase
  end

  // extension word recognition by opcode range
  assign is_ext = (i_req.ext_word >= CITIM_EXT_LO) &&
                  (i_req.ext_word <= CITIM_EXT_HI);

  logic is_instr;
  logic ext_applies;
  logic reg_form;
  logic [2:0] total_words;

  assign is_instr = (i_req.cls == CITIM_CLS_FMT1) ||
                    (i_req.cls == CITIM_CLS_FMT2_ROT) ||
                    (i_req.cls == CITIM_CLS_FMT2_PUSH) ||
                    (i_req.cls == CITIM_CLS_FMT2_CALL);
  assign ext_applies = is_ext && is_instr;

  always_comb begin
    reg_form = 1'b0;
    if (i_req.cls == CITIM_CLS_FMT1) begin
      reg_form = (i_req.src_mode == CITIM_AM_REG) &&
                 (i_req.dst_mode == CITIM_AM_REG);
    end else begin
      reg_form = (i_req.dst_mode == CITIM_AM_REG);
    end
  end

  always_comb begin
    kind_nxt = CITIM_EXT_NONE;
    if (ext_applies) begin
      kind_nxt = reg_form ? CITIM_EXT_REGISTER : CITIM_EXT_NONREG;
    end
  end

  // leading extension word counts unless the form is defined without it
  always_comb begin
    total_words = {1'b0, words_nxt};
    if (ext_applies && !i_req.ext_free) begin
      total_words = {1'b0, words_nxt} + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // execution sequencing

  typedef enum logic [1:0] {
    CITIM_ST_IDLE,
    CITIM_ST_EXEC
  } citim_state_t;

  citim_state_t state_r;
  logic [2:0] left_r;
  logic [19:0] pc_r;
  logic [19:0] pc_step_r;
  logic take;

  assign o_ready = (state_r == CITIM_ST_IDLE);
  assign take = i_valid && o_ready;
  assign o_busy = (state_r == CITIM_ST_EXEC);
  assign o_last_cycle = (state_r == CITIM_ST_EXEC) && (left_r == 3'h1);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= CITIM_ST_IDLE;
      left_r <= 3'h0;
    end else begin
      case (state_r)
        CITIM_ST_IDLE: begin
          if (take) begin
            state_r <= CITIM_ST_EXEC;
            left_r <= cyc_nxt;
          end
        end
        CITIM_ST_EXEC: begin
          if (left_r == 3'h1) begin
            state_r <= CITIM_ST_IDLE;
            left_r <= 3'h0;
          end else begin
            left_r <= left_r - 3'h1;
          end
        end
        default: begin
          state_r <= CITIM_ST_IDLE;
          left_r <= 3'h0;
        end
      endcase
    end
  end

  // response captured at acceptance
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rsp <= '0;
      o_rsp_valid <= 1'b0;
    end else begin
      o_rsp_valid <= take;
      if (take) begin
        o_rsp.cycles <= cyc_nxt;
        o_rsp.words <= total_words;
        o_rsp.ext_kind <= kind_nxt;
        o_rsp.wide <= ext_applies;
        o_rsp.ext_err <= is_ext && !is_instr;
      end
    end
  end

  // program counter: bytes = 2 per word, applied on the final cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pc_r <= CITIM_PC_RESET;
      pc_step_r <= 20'h00000;
    end else begin
      if (take) begin
        pc_step_r <= CITIM_WORD_BYTES * {17'h00000, total_words};
      end
      if (o_last_cycle) begin
        pc_r <= pc_r + pc_step_r;
      end
    end
  end

  assign o_pc = pc_r;

endmodule

`default_nettype wire

// ===== test/citim_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module citim_assertions
  import citim_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire citim_pkg::citim_req_t i_req,
  input wire logic o_ready,
  input wire citim_pkg::citim_rsp_t o_rsp,
  input wire logic o_rsp_valid,
  input wire logic [19:0] o_pc,
  input wire logic o_busy,
  input wire logic o_last_cycle
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  logic take;
  logic plain;
  logic [3:0] busy_cnt_r;
  assign take = i_valid && o_ready;
  // plain: no extension word in front of the request
  assign plain = (i_req.ext_word < CITIM_EXT_LO) ||
                 (i_req.ext_word > CITIM_EXT_HI);

  //////////////////////////////////////////////////////////////////////////
  // busy cycles elapsed in the current execution
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_busy) begin
      busy_cnt_r <= 4'h0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  a_take_answer: assert property (take |=> o_rsp_valid && o_busy && !o_ready)
    else $error("no answer after an accepted request");
  a_busy_count: assert property (o_last_cycle |-> o_busy &&
      busy_cnt_r + 4'h1 == {1'b0, o_rsp.cycles})
    else $error("busy length differs from reported cycles");
  a_int_exit: assert property (take && plain &&
      i_req.cls == CITIM_CLS_INTERRUPT_EXIT
      |=> o_rsp.cycles == 3'h5 && o_rsp.words == 2'h1)
    else $error("interrupt exit timing wrong");
  a_sub_exit: assert property (take && plain &&
      i_req.cls == CITIM_CLS_SUBROUTINE_EXIT
      |=> o_rsp.cycles == 3'h4 && o_rsp.words == 2'h1)
    else $error("subroutine exit timing wrong");
  a_irq_six: assert property (take && plain &&
      i_req.cls == CITIM_CLS_IRQ_SERVICE |=> o_rsp.cycles == 3'h6)
    else $error("interrupt service timing wrong");
  a_reset_four: assert property (take && plain &&
      (i_req.cls == CITIM_CLS_WATCHDOG_RESET ||
       i_req.cls == CITIM_CLS_PIN_RESET) |=> o_rsp.cycles == 3'h4)
    else $error("reset sequence timing wrong");
  a_jump_two: assert property (take && plain &&
      i_req.cls == CITIM_CLS_JUMP
      |=> o_rsp.cycles == 3'h2 && o_rsp.words == 2'h1)
    else $error("jump timing wrong");
  a_pc_step: assert property (o_last_cycle |=>
      o_pc == $past(o_pc) + 20'({$past(o_rsp.words), 1'b0}))
    else $error("program counter step wrong");
  a_ext_wide: assert property (take && !plain && !i_req.ext_free &&
      i_req.cls == CITIM_CLS_FMT1 |=> o_rsp.wide && o_rsp.words >= 2'h2)
    else $error("extension word not honoured");
endmodule

`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import citim_pkg::*;

  typedef struct packed {
    citim_req_t req;
    citim_rsp_t rsp;
  } citim_row_t;

  logic i_core_clk;
  logic i_rst;
  logic i_valid;
  citim_req_t i_req;
  logic o_ready;
  citim_rsp_t o_rsp;
  logic o_rsp_valid;
  logic [19:0] o_pc;
  logic o_busy;
  logic o_last_cycle;
  logic [19:0] exp_pc;
  int errors = 0;
  int checks_done = 0;
  citim_row_t rows[$];

  citim_decoder citim_decoder_inst (.i_core_clk, .i_rst, .i_valid, .i_req,
    .o_ready, .o_rsp, .o_rsp_valid, .o_pc, .o_busy, .o_last_cycle);

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] g, logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // c class, s/d modes, f bit0 fast op bit1 no extra word, y cycles,
  // w words, e ext word, k ext kind
  task automatic add(int c, s, d, f, y, w, logic [15:0] e = 16'h0000,
                     int k = 0);
    citim_row_t r;
    logic err;
    err = (e >= CITIM_EXT_LO) && (e <= CITIM_EXT_HI) && (c < 1 || c > 4);
    r.req = '{citim_class_t'(c), citim_amode_t'(s), citim_amode_t'(d),
              1'(f), 1'(f >> 1), e};
    r.rsp = '{3'(y), 3'(w), citim_ext_t'(k), k != 0, err};
    rows.push_back(r);
  endtask

  // entered at a falling edge; hold keeps a refused request up while busy
  task automatic run(citim_row_t w, logic hold);
    int n;
    n = 0;
    i_valid = 1'b1;
    i_req = w.req;
    @(negedge i_core_clk);
    i_valid = hold;
    if (hold) begin
      i_req = rows[0].req;
    end
    chk(o_rsp_valid, 1);
    chk(o_rsp, w.rsp);
    while (o_busy === 1'b1 && n < 20) begin
      n++;
      @(negedge i_core_clk);
    end
    chk(n, w.rsp.cycles);
    exp_pc = exp_pc + 20'(2 * w.rsp.words);
    chk(o_pc, exp_pc);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge i_core_clk);
    errors++;
    give_verdict;
  end

  initial begin
    i_rst = 1'b1;
    i_valid = 1'b0;
    i_req = '0;
    exp_pc = 20'h00000;
    add(6, 0, 0, 0, 5, 1); add(7, 0, 0, 0, 4, 1);
    add(8, 0, 0, 0, 6, 0); add(9, 0, 0, 0, 4, 0);
    add(10, 0, 0, 0, 4, 0); add(5, 0, 0, 0, 2, 1);
    add(2, 0, 0, 0, 1, 1); add(2, 1, 1, 0, 3, 1);
    add(2, 2, 2, 0, 3, 1); add(2, 4, 4, 0, 4, 2); add(2, 6, 6, 0, 4, 2);
    add(3, 0, 0, 0, 3, 1); add(3, 2, 2, 0, 3, 1); add(3, 3, 3, 0, 3, 2);
    add(3, 5, 5, 0, 4, 2); add(3, 6, 6, 0, 4, 2);
    add(4, 0, 0, 0, 4, 1); add(4, 3, 3, 0, 4, 2); add(4, 4, 4, 0, 5, 2);
    add(4, 5, 5, 0, 5, 2); add(4, 6, 6, 0, 6, 2);
    add(1, 0, 0, 0, 1, 1); add(1, 0, 7, 0, 3, 1); add(1, 0, 4, 0, 4, 2);
    add(1, 1, 0, 0, 2, 1); add(1, 2, 7, 0, 4, 1); add(1, 1, 5, 0, 5, 2);
    add(1, 3, 0, 0, 2, 2); add(1, 3, 7, 0, 3, 2); add(1, 3, 6, 0, 5, 3);
    add(1, 4, 0, 0, 3, 2); add(1, 6, 7, 0, 5, 2); add(1, 5, 4, 0, 6, 3);
    add(1, 0, 6, 1, 3, 2); add(1, 3, 4, 1, 4, 3); add(1, 5, 6, 1, 5, 3);
    add(1, 0, 0, 1, 1, 1); add(1, 4, 7, 1, 5, 2);
    add(1, 0, 0, 0, 1, 2, 16'h1800, 1); add(3, 0, 0, 0, 3, 2, 16'h1800, 1);
    add(1, 1, 5, 0, 5, 3, 16'h1FFF, 2); add(1, 0, 7, 0, 3, 2, 16'h1C00, 2);
    add(1, 0, 0, 0, 1, 1, 16'h17FF); add(1, 0, 0, 0, 1, 1, 16'h2000);
    add(1, 4, 4, 0, 6, 4, 16'h1880, 2); add(1, 0, 0, 2, 1, 1, 16'h1800, 1);
    add(5, 0, 0, 0, 2, 1, 16'h1800);
    repeat (5) @(negedge i_core_clk);
    i_rst = 1'b0;
    chk(o_ready, 1);
    foreach (rows[j]) begin
      run(rows[j], 1'b0);
    end
    // refused request held during a service sequence, then taken at once
    run(rows[2], 1'b1);
    run(rows[0], 1'b0);
    // reset in the middle of a call
    i_valid = 1'b1;
    i_req = rows[20].req;
    @(negedge i_core_clk);
    i_valid = 1'b0;
    @(negedge i_core_clk);
    i_rst = 1'b1;
    @(negedge i_core_clk);
    i_rst = 1'b0;
    exp_pc = 20'h00000;
    chk({o_busy, o_ready, o_rsp_valid}, 3'h2);
    chk(o_pc, exp_pc);
    run(rows[20], 1'b0);
    give_verdict;
  end
endmodule

bind citim_decoder citim_assertions citim_assertions_inst (.i_core_clk,
  .i_rst, .i_valid, .i_req, .o_ready, .o_rsp, .o_rsp_valid, .o_pc, .o_busy,
  .o_last_cycle);

`default_nettype wire
